// [hmp_host_model.sv]
// behavioural host master driving the microinterface pins
`timescale 1ns/1ps
`default_nettype none
module hmp_host_model (
    input wire logic clk_i,
    input wire logic bclk_i,
    input wire logic ack_n_i,
    input wire logic tea_n_i,
    input wire logic [0:15] rdata_i,
    output logic cs_n_o,
    output logic rnw_o,
    output logic [0:6] addr_o,
    output logic [0:15] wdata_o
);
    logic bclk_q = 1'b0;
    int misses = 0;
    initial begin
        cs_n_o = 1'b1;
        rnw_o = 1'b1;
        addr_o = 7'h00;
        wdata_o = 16'h0000;
    end
    // previous bclk sample, so a rise shows at the clk edge after it
    always @(posedge clk_i) bclk_q <= bclk_i;
    // one access: cs_n low for some bclk rises; in handshake mode also until acked
    task automatic access(input logic r, input logic [6:0] a, input logic [15:0] v,
        input int rises, input logic hs, output logic [15:0] rd, output int ackc,
        output int teac);
        int seen;
        logic found;
        seen = 0;
        ackc = 0;
        teac = 0;
        rd = 16'h0000;
        found = 1'b0;
        // bounded wait for a bclk rise; a miss is counted in misses for the bench to check
        for (int i = 0; i < 12 && !found; i++) begin
            @(posedge clk_i);
            found = bclk_i && !bclk_q;
        end
        if (!found) misses++;
        // request changes only just after a bclk rise
        cs_n_o <= 1'b0;
        rnw_o <= r;
        addr_o <= a;
        wdata_o <= r ? ~wdata_o : v;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk_i);
            if (!ack_n_i && ackc == 0) rd = rdata_i;
            if (!ack_n_i) ackc++;
            if (!tea_n_i) teac++;
            if (bclk_i && !bclk_q && !cs_n_o) seen++;
            // released lines show the inverse, never a stale copy
            if (!cs_n_o && seen >= rises && (!hs || ackc > 0)) begin
                cs_n_o <= 1'b1;
                wdata_o <= ~wdata_o;
            end
        end
        @(posedge clk_i);
        cs_n_o <= 1'b1;
    endtask : access
endmodule : hmp_host_model
`default_nettype wire

// [hmp_mem.sv]
// small register-file memory behind the host port, registered read data
`timescale 1ns/1ps
`default_nettype none
module hmp_mem #(
    parameter int AW = 6,
    parameter int DW = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic we_i,
    input wire logic [1:0] be_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    localparam int HW = DW / 2;
    logic [DW-1:0] mem_reg [2**AW];
    logic [DW-1:0] rdata_reg;

    // byte-lane writes; contents are not reset, software sets them up
    always_ff @(posedge clk_i) begin
        if (we_i && be_i[1]) begin
            mem_reg[addr_i][DW-1:HW] <= wdata_i[DW-1:HW];
        end
        if (we_i && be_i[0]) begin
            mem_reg[addr_i][HW-1:0] <= wdata_i[HW-1:0];
        end
    end

    // read every cycle so the data stand one clock after the address
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= mem_reg[addr_i];
        end
    end

    assign rdata_o = rdata_reg;
endmodule : hmp_mem
`default_nettype wire

// [hmp_pkg.sv]
// package: constants, pin bundle and helpers for the host microinterface port
// How it works
// - burst mode only while burst select high
// - little endian swaps bytes both ways
// - invariance select used only in little endian
// - address line zero is the msb
// - width strap high gives 8-bit path
// - handshake strap high holds acknowledge
// - burst mode: straps become size bits
// - device acknowledges each legal cycle, active low
// - direction high reads, low writes
// - 16-bit data, line zero is msb
// - one-cycle error pulse on illegal request
// - byte and word accesses both accepted
package hmp_pkg;
    localparam int CLK_MHZ = 100;
    localparam int BCLK_MAX_MHZ = 60;
    // plain register port map
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_COUNT = 4'h8;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'h1;
    // burst transfer size codes {size_bit1, size_bit0}
    localparam logic [1:0] SIZ_BYTE = 2'h1;
    localparam logic [1:0] SIZ_WORD = 2'h2;
    localparam logic [1:0] BE_WORD = 2'h3;
    localparam logic [1:0] BE_HI = 2'h2;
    localparam logic [1:0] BE_LO = 2'h1;
    localparam int MEM_AW = 6;
    localparam int DATA_W = 16;

    // everything that crosses in from the host pins
    typedef struct packed {
        logic bclk;
        logic cs_n;
        logic rnw;
        logic burst;
        logic le;
        logic dinv;
        logic siz1;
        logic siz0;
        logic [6:0] addr;
        logic [15:0] data;
    } hmp_pins_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_ACK = 2'b10,
        ST_HOLD = 2'b11
    } hmp_state_e;

    function automatic logic [15:0] swap16(input logic [15:0] v);
        swap16 = {v[7:0], v[15:8]};
    endfunction : swap16
endpackage : hmp_pkg

// [hmp_port.sv]
// host microinterface port: pin sampling, cycle handshake, endian handling
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hmp_port (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic host_bclk_i,
    input wire logic burst_host_mode_select_i,
    input wire logic little_endian_select_i,
    input wire logic invariance_select_i,
    input wire logic width_strap_or_size_bit0_i,
    input wire logic handshake_strap_or_size_bit1_i,
    input wire logic [0:6] host_address_bus_i,
    input wire logic cycle_start_n_i,
    input wire logic host_read_not_write_i,
    input wire logic [0:15] host_data_bus_i,
    output logic [0:15] host_data_bus_o,
    output logic host_data_bus_oe_n_o,
    output logic cycle_acknowledge_n_o,
    output logic transfer_error_n_o,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o
);
    hmp_pkg::hmp_pins_s pins_raw;
    hmp_pkg::hmp_pins_s s1_reg;
    hmp_pkg::hmp_pins_s s2_reg;
    hmp_pkg::hmp_pins_s s3_reg;
    hmp_pkg::hmp_pins_s pin_reg;
    hmp_pkg::hmp_state_e state_reg;
    logic bclk_d_reg;
    logic samp;
    logic en_reg;
    logic ack_n_reg;
    logic tea_n_reg;
    logic oe_n_reg;
    logic [15:0] dout_reg;
    logic bus8_reg;
    logic sw_reg;
    logic lane_lo_reg;
    logic [15:0] acc_cnt_reg;
    logic [15:0] err_cnt_reg;
    logic [31:0] rdata_reg;
    logic burst;
    logic [1:0] size;
    logic bus8;
    logic hshake;
    logic byte_acc;
    logic size_err;
    logic sw;
    logic start;
    logic legal_start;
    logic burst_overrun;
    logic illegal;
    logic mem_we;
    logic [1:0] mem_be;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic [15:0] rd_fmt;
    logic cnt_clr;

    // port vectors run msb-first from line 0, so a plain copy keeps line 0 on top
    assign pins_raw.bclk = host_bclk_i;
    assign pins_raw.cs_n = cycle_start_n_i;
    assign pins_raw.rnw = host_read_not_write_i;
    assign pins_raw.burst = burst_host_mode_select_i;
    assign pins_raw.le = little_endian_select_i;
    assign pins_raw.dinv = invariance_select_i;
    assign pins_raw.siz1 = handshake_strap_or_size_bit1_i;
    assign pins_raw.siz0 = width_strap_or_size_bit0_i;
    assign pins_raw.addr = host_address_bus_i;
    assign pins_raw.data = host_data_bus_i;

    // three-stage sampling; a bit moves only when stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            pin_reg <= '0;
            bclk_d_reg <= 1'b0;
        end else begin
            s1_reg <= pins_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg | s3_reg));
            bclk_d_reg <= pin_reg.bclk;
        end
    end

    // sample at the falling bus-clock edge, mid-cycle, where host signals are settled
    assign samp = bclk_d_reg & ~pin_reg.bclk;

    // mode decode from the straps; they are assumed static while busy
    assign burst = pin_reg.burst;
    assign size = {pin_reg.siz1, pin_reg.siz0};
    assign bus8 = !burst && pin_reg.siz0;
    assign hshake = !burst && pin_reg.siz1;
    assign byte_acc = bus8 || (burst && size == hmp_pkg::SIZ_BYTE);
    assign size_err = burst && size != hmp_pkg::SIZ_BYTE && size != hmp_pkg::SIZ_WORD;
    // words always swap in little endian; byte lanes swap only when data invariant
    assign sw = pin_reg.le && (!byte_acc || pin_reg.dinv);

    assign start = samp && state_reg == hmp_pkg::ST_IDLE && !pin_reg.cs_n && en_reg;
    assign legal_start = start && !size_err;
    assign burst_overrun = samp && state_reg == hmp_pkg::ST_ACK && burst && !pin_reg.cs_n;
    assign illegal = (start && size_err) || burst_overrun;

    // write path into the register file, byte enables from size and address
    assign mem_we = legal_start && !pin_reg.rnw;
    always_comb begin
        if (!byte_acc) begin
            mem_be = hmp_pkg::BE_WORD;
        end else if (pin_reg.addr[0]) begin
            mem_be = hmp_pkg::BE_LO;
        end else begin
            mem_be = hmp_pkg::BE_HI;
        end
    end
    always_comb begin
        if (bus8) begin
            mem_wdata = {pin_reg.data[15:8], pin_reg.data[15:8]};
        end else if (sw) begin
            mem_wdata = hmp_pkg::swap16(pin_reg.data);
        end else begin
            mem_wdata = pin_reg.data;
        end
    end

    hmp_mem #(
        .AW(hmp_pkg::MEM_AW),
        .DW(hmp_pkg::DATA_W)
    ) u_mem (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(mem_we),
        .be_i(mem_be),
        .addr_i(pin_reg.addr[6:1]),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata)
    );

    // read data formatting; 8-bit path returns the addressed byte on lines 0-7
    always_comb begin
        if (bus8_reg) begin
            rd_fmt = {(lane_lo_reg ? mem_rdata[7:0] : mem_rdata[15:8]), 8'h00};
        end else if (sw_reg) begin
            rd_fmt = hmp_pkg::swap16(mem_rdata);
        end else begin
            rd_fmt = mem_rdata;
        end
    end

    // access sequencer; acknowledge lasts one bus cycle or, in handshake, until release
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= hmp_pkg::ST_IDLE;
            ack_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            dout_reg <= 16'h0000;
            bus8_reg <= 1'b0;
            sw_reg <= 1'b0;
            lane_lo_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                hmp_pkg::ST_IDLE: begin
                    if (legal_start) begin
                        bus8_reg <= bus8;
                        sw_reg <= sw;
                        lane_lo_reg <= pin_reg.addr[0];
                        if (pin_reg.rnw) begin
                            state_reg <= hmp_pkg::ST_READ;
                        end else begin
                            state_reg <= hmp_pkg::ST_ACK;
                            ack_n_reg <= 1'b0;
                        end
                    end
                end
                hmp_pkg::ST_READ: begin
                    dout_reg <= rd_fmt;
                    oe_n_reg <= 1'b0;
                    ack_n_reg <= 1'b0;
                    state_reg <= hmp_pkg::ST_ACK;
                end
                hmp_pkg::ST_ACK: begin
                    if (samp) begin
                        if (hshake && !pin_reg.cs_n) begin
                            state_reg <= hmp_pkg::ST_HOLD;
                        end else begin
                            ack_n_reg <= 1'b1;
                            oe_n_reg <= 1'b1;
                            state_reg <= hmp_pkg::ST_IDLE;
                        end
                    end
                end
                hmp_pkg::ST_HOLD: begin
                    if (pin_reg.cs_n) begin
                        ack_n_reg <= 1'b1;
                        oe_n_reg <= 1'b1;
                        state_reg <= hmp_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // error strobe spans exactly one sampled bus cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tea_n_reg <= 1'b1;
        end else if (samp) begin
            tea_n_reg <= !illegal;
        end
    end

    // counters; a count in the clearing cycle survives the clear
    assign cnt_clr = reg_write_i && reg_addr_i == hmp_pkg::REG_COUNT;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_cnt_reg <= 16'h0000;
            err_cnt_reg <= 16'h0000;
        end else begin
            acc_cnt_reg <= (cnt_clr ? 16'h0000 : acc_cnt_reg) + {15'h0000, legal_start};
            err_cnt_reg <= (cnt_clr ? 16'h0000 : err_cnt_reg) + {15'h0000, illegal};
        end
    end

    // control register: enable gates new host cycles, an access in flight completes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_reg <= hmp_pkg::CTRL_EN_RESET;
        end else if (reg_write_i && reg_addr_i == hmp_pkg::REG_CTRL) begin
            en_reg <= reg_wdata_i[hmp_pkg::CTRL_EN_BIT];
        end
    end

    // register read, data one cycle after the strobe, zero elsewhere
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (reg_read_i) begin
            unique case (reg_addr_i)
                hmp_pkg::REG_CTRL: rdata_reg <= {31'h0000_0000, en_reg};
                hmp_pkg::REG_STATUS: rdata_reg <= {22'h00_0000, state_reg, pin_reg.burst,
                    pin_reg.le, pin_reg.dinv, pin_reg.siz1, pin_reg.siz0, oe_n_reg,
                    ack_n_reg, tea_n_reg};
                hmp_pkg::REG_COUNT: rdata_reg <= {err_cnt_reg, acc_cnt_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign host_data_bus_o = dout_reg;
    assign host_data_bus_oe_n_o = oe_n_reg;
    assign cycle_acknowledge_n_o = ack_n_reg;
    assign transfer_error_n_o = tea_n_reg;
    assign reg_rdata_o = rdata_reg;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // error pulse is released by the next sample, which comes within one bus period
    a_tea_one_cycle: assert property ($fell(transfer_error_n_o) |->
        !transfer_error_n_o [*3] ##[1:40] $rose(transfer_error_n_o))
        else $error("error strobe not one bus cycle");
    a_tea_has_cause: assert property ($fell(transfer_error_n_o) |-> $past(illegal))
        else $error("error strobe without illegal request");
    a_ack_after_write: assert property (mem_we |=> !cycle_acknowledge_n_o)
        else $error("write not acknowledged");
    a_read_drives_bus: assert property (legal_start && pin_reg.rnw |->
        ##2 (!host_data_bus_oe_n_o && !cycle_acknowledge_n_o))
        else $error("read data not driven with acknowledge");
    a_write_no_drive: assert property (mem_we |=> host_data_bus_oe_n_o [*8])
        else $error("bus driven on a write");
    a_burst_only_sel: assert property (!pin_reg.burst |-> !size_err && !burst_overrun)
        else $error("burst handling outside burst mode");
    a_le_word_swap: assert property (mem_we && pin_reg.le && !bus8 && !byte_acc |->
        mem_wdata == hmp_pkg::swap16(pin_reg.data))
        else $error("little endian word not swapped");
    a_be_no_swap: assert property (mem_we && !pin_reg.le && !bus8 |->
        mem_wdata == pin_reg.data)
        else $error("big endian data swapped");
    a_bus8_byte_lane: assert property (mem_we && bus8 |->
        mem_be != hmp_pkg::BE_WORD && mem_wdata[7:0] == pin_reg.data[15:8])
        else $error("8-bit path wrote a word");
    a_hold_until_rel: assert property (state_reg == hmp_pkg::ST_HOLD && !pin_reg.cs_n |=>
        !cycle_acknowledge_n_o)
        else $error("handshake acknowledge released early");
    a_size_burst_bits: assert property (start && pin_reg.burst && size == hmp_pkg::SIZ_WORD |->
        !illegal && !byte_acc)
        else $error("burst word size misread");
endmodule : hmp_port
`default_nettype wire

// [hmp_port_tb.sv]
// self-checking bench for the host microinterface port
`timescale 1ns/1ps
`default_nettype none
module hmp_port_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic bclk = 1'b0;
    logic burst = 1'b0, le = 1'b0, dinv = 1'b0, s1 = 1'b0, s0 = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_write = 1'b0, reg_read = 1'b0;
    logic [31:0] reg_rdata, rv;
    logic cs_n, rnw, oe_n, ack_n, tea_n;
    logic [0:6] addr;
    logic [0:15] hwd, dout, din;
    logic [15:0] rd, d;
    logic [5:0] w;
    int ackc, teac, num_errors = 0, num_checks = 0;
    int seed = 32'he282_90a0;

    always #5 clk_i = ~clk_i;
    // 80 ns host clock, phase offset from clk_i, far below the ceiling
    initial begin
        #3;
        forever #40 bclk = ~bclk;
    end
    // shared data bus: device wins while its enable is low
    assign din = oe_n ? hwd : dout;

    hmp_port hmp_port_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .host_bclk_i(bclk),
        .burst_host_mode_select_i(burst), .little_endian_select_i(le),
        .invariance_select_i(dinv), .width_strap_or_size_bit0_i(s0),
        .handshake_strap_or_size_bit1_i(s1), .host_address_bus_i(addr),
        .cycle_start_n_i(cs_n), .host_read_not_write_i(rnw), .host_data_bus_i(din),
        .host_data_bus_o(dout), .host_data_bus_oe_n_o(oe_n), .cycle_acknowledge_n_o(ack_n),
        .transfer_error_n_o(tea_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_write_i(reg_write), .reg_read_i(reg_read), .reg_rdata_o(reg_rdata));
    hmp_host_model hmp_host_model_inst (.clk_i(clk_i), .bclk_i(bclk), .ack_n_i(ack_n),
        .tea_n_i(tea_n), .rdata_i(din), .cs_n_o(cs_n), .rnw_o(rnw), .addr_o(addr),
        .wdata_o(hwd));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk_i);
        reg_write <= 1'b0;
    endtask : reg_wr
    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk_i);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_i);
        reg_read <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask : reg_rd
    // straps {burst, le, dinv, s1, s0} change only while the port is idle
    task automatic set_mode(input logic [4:0] m);
        @(posedge clk_i);
        {burst, le, dinv, s1, s0} <= m;
        repeat (12) @(posedge clk_i);
    endtask : set_mode
    task automatic host(input logic r, input logic [6:0] a, input logic [15:0] v,
        input int rises, input logic hs);
        hmp_host_model_inst.access(r, a, v, rises, hs, rd, ackc, teac);
    endtask : host
    function automatic logic ack_len_ok();
        ack_len_ok = ackc >= 7 && ackc <= 9 && teac == 0;
    endfunction : ack_len_ok
    function automatic logic tea_only();
        tea_only = ackc == 0 && teac >= 7 && teac <= 9;
    endfunction : tea_only

    // a hang ends in the closing report as a failure
    initial begin
        #900_000;
        num_errors++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        reg_rd(hmp_pkg::REG_CTRL);
        check("ctrl reset", 32'h0000_0001, rv);
        reg_rd(4'hc);
        check("unmapped", 32'h0000_0000, rv);
        reg_wr(hmp_pkg::REG_STATUS, 32'hffff_ffff);
        reg_rd(hmp_pkg::REG_STATUS);
        check("status idle", 32'h0000_0007, rv);
        reg_wr(hmp_pkg::REG_COUNT, 32'h0000_0000);
        // random big-endian word traffic across the address space
        for (int i = 0; i < 6; i++) begin
            w = 6'($random(seed));
            d = 16'($random(seed));
            host(1'b0, {w, 1'b0}, d, 1, 1'b0);
            check("write ack", 32'h1, {31'h0, ack_len_ok()});
            host(1'b1, {w, 1'b0}, 16'h0000, 1, 1'b0);
            check("read word", {16'h0, d}, {16'h0, rd});
        end
        reg_rd(hmp_pkg::REG_COUNT);
        check("count", 32'h0000_000c, rv);
        // little endian seen from both sides, invariance has no say on words
        set_mode(5'h08);
        host(1'b1, {w, 1'b0}, 16'h0000, 1, 1'b0);
        check("le read", {16'h0, d[7:0], d[15:8]}, {16'h0, rd});
        for (int k = 0; k < 2; k++) begin
            set_mode(5'h08 | {k[0], 2'h0});
            d = 16'($random(seed));
            host(1'b0, {w, 1'b0}, d, 1, 1'b0);
            set_mode(5'h00);
            host(1'b1, {w, 1'b0}, 16'h0000, 1, 1'b0);
            check("le write", {16'h0, d[7:0], d[15:8]}, {16'h0, rd});
        end
        // 8-bit path: bytes on lines 0-7, lane by the last address line
        set_mode(5'h01);
        d = 16'($random(seed));
        host(1'b0, {w, 1'b0}, d, 1, 1'b0);
        host(1'b0, {w, 1'b1}, {d[7:0], d[15:8]}, 1, 1'b0);
        host(1'b1, {w, 1'b0}, 16'h0000, 1, 1'b0);
        check("byte hi", {16'h0, d[15:8], 8'h00}, {16'h0, rd});
        host(1'b1, {w, 1'b1}, 16'h0000, 1, 1'b0);
        check("byte lo", {16'h0, d[7:0], 8'h00}, {16'h0, rd});
        set_mode(5'h00);
        host(1'b1, {w, 1'b0}, 16'h0000, 1, 1'b0);
        check("byte word", {16'h0, d}, {16'h0, rd});
        // handshake holds the acknowledge while cycle start stays low
        set_mode(5'h02);
        host(1'b0, {w, 1'b0}, d, 3, 1'b1);
        check("hs ack", 32'h1, {31'h0, ackc >= 14});
        // burst mode: straps become size bits
        reg_wr(hmp_pkg::REG_COUNT, 32'h0000_0000);
        set_mode(5'h12);
        d = 16'($random(seed));
        host(1'b0, {w, 1'b0}, d, 1, 1'b0);
        host(1'b1, {w, 1'b0}, 16'h0000, 1, 1'b0);
        check("burst word", {16'h0, d}, {16'h0, rd});
        set_mode(5'h11);
        host(1'b0, {w, 1'b1}, d, 1, 1'b0);
        check("burst byte", 32'h1, {31'h0, ack_len_ok()});
        for (int k = 0; k < 2; k++) begin
            set_mode(5'h10 | {3'h0, k[0], k[0]});
            host(1'b0, {w, 1'b0}, d, 1, 1'b0);
            check("size error", 32'h1, {31'h0, tea_only()});
        end
        reg_rd(hmp_pkg::REG_COUNT);
        check("burst count", 32'h0002_0003, rv);
        reg_rd(hmp_pkg::REG_STATUS);
        check("status straps", 32'h0000_0013, {27'h0, rv[7:3]});
        set_mode(5'h12);
        host(1'b0, {w, 1'b0}, d, 2, 1'b0);
        check("long start", 32'h1, {31'h0, ackc > 0 && teac >= 7 && teac <= 9});
        // burst byte in little endian: only data invariant swaps the lane
        for (int k = 0; k < 2; k++) begin
            set_mode(5'h19 | {k[0], 2'h0});
            d = 16'($random(seed));
            host(1'b0, {w, 1'b1}, d, 1, 1'b0);
            set_mode(5'h00);
            host(1'b1, {w, 1'b0}, 16'h0000, 1, 1'b0);
            check("le byte lane", {24'h0, (k[0] ? d[15:8] : d[7:0])}, {24'h0, rd[7:0]});
        end
        // disabled port ignores cycles; reset brings the enable back
        set_mode(5'h00);
        reg_wr(hmp_pkg::REG_CTRL, 32'h0000_0000);
        host(1'b0, {w, 1'b0}, d, 1, 1'b0);
        check("disabled", 32'h0, 32'(ackc + teac));
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        reg_rd(hmp_pkg::REG_CTRL);
        check("ctrl again", 32'h0000_0001, rv);
        host(1'b0, {w, 1'b0}, d, 1, 1'b0);
        check("after reset", 32'h1, {31'h0, ack_len_ok()});
        check("bclk waits", 32'h0, 32'(hmp_host_model_inst.misses));
        final_report();
    end
endmodule : hmp_port_tb
`default_nettype wire
